// ===== verilog/pmc_pkg.sv
// Constants and types shared by the C2 entry and general event status logic.
// How it works
// - Level-2 trigger reads always return zero.
// - Level-2 trigger writes are ignored entirely.
// - Trigger read holds stop clock until break.
// - Throttling ignored while in C2 state.
// - GPI flag sets on input pin level, invertible.
// - Enabled GPI flag wakes from S1-S5.
// - Enabled GPI flag in S0 raises routed SCI.
// - Enabled flag in S0: SCI or SMI.
// - Thermal override flag never signals anything.
// - Reset-control port reset keeps status bits.
// - Resume-well reset clears all status bits.
// - Bus-0 flag sets on internal power event.
// - Bus-0 flag clears on write one.
// - Enabled bus-0 flag in S0: SCI/SMI.
// - Bus-0 flag in sleep: wake plus SCI/SMI.
// - Override S5: bus-0 flag stays silent.
package pmc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [15:0] TRIG_OFFSET = 16'h0014;
    localparam logic [15:0] GES_OFFSET = 16'h0028;
    localparam logic [7:0] TRIG_READ_VALUE = 8'h00;
    localparam logic [31:0] GES_RESET = 32'h00000000;
    localparam logic [31:0] GES_IMPL_MASK = 32'hFFFF2000;
    localparam int GPI_LSB = 16;
    localparam int GPI_COUNT = 16;
    localparam int BUS0_BIT = 13;
    localparam int BUS0_DEVICES = 8;

    // ****************************************
    // Routing, pins and timing
    // ****************************************
    localparam logic [1:0] ROUTE_SMI = 2'h1;
    localparam logic [1:0] ROUTE_SCI = 2'h2;
    localparam logic [16:0] PIN_IDLE = 17'h10000;
    localparam logic [1:0] SYNC_FILL = 2'h3;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0]
    {
        PMC_S0 = 3'h0,
        PMC_S1 = 3'h1,
        PMC_S2 = 3'h2,
        PMC_S3 = 3'h3,
        PMC_S4 = 3'h4,
        PMC_S5 = 3'h5
    } pmc_sleep_type;

    typedef enum logic [1:0]
    {
        PMC_C2_RUN = 2'b01,
        PMC_C2_SLEEP = 2'b10
    } pmc_c2_state_type;

endpackage

// ===== verilog/pmc_status_if.sv
// Carrier between the status keeper and the logic that sets, clears and reads it.
`timescale 1ns/1ps
interface pmc_status_if;
    logic [31:0] set_mask;
    logic [31:0] clear_mask;
    logic [31:0] status;
    logic [31:0] fresh;

    modport keeper
    (
        input set_mask,
        input clear_mask,
        output status,
        output fresh
    );

    modport user
    (
        output set_mask,
        output clear_mask,
        input status,
        input fresh
    );
endinterface

// ===== verilog/pmc_event_status.sv
// Sticky general event status bits, kept in the resume well.
`timescale 1ns/1ps
module pmc_event_status
(
    // Clock and resume-well reset
    input wire logic clk,
    input wire logic resume_well_reset_n,
    // Status access
    pmc_status_if.keeper sts
);
    import pmc_pkg::*;

    // ****************************************
    // Status bits
    // ****************************************
    // Only the resume-well reset reaches these flops, so a core reset leaves them alone.
    always_ff @(posedge clk or negedge resume_well_reset_n)
    begin
        if (!resume_well_reset_n)
        begin
            sts.status <= GES_RESET;
        end
        else
        begin
            // A set in the same cycle as a clear wins, so no event is lost.
            sts.status <= ((sts.status & ~sts.clear_mask) | sts.set_mask) & GES_IMPL_MASK;
        end
    end

    always_ff @(posedge clk or negedge resume_well_reset_n)
    begin
        if (!resume_well_reset_n)
        begin
            sts.fresh <= GES_RESET;
        end
        else
        begin
            sts.fresh <= sts.set_mask & ~sts.status & GES_IMPL_MASK;
        end
    end

endmodule

// ===== verilog/pmc_c2_ctrl.sv
// Stop-clock control for level-2 entry and throttling.
`timescale 1ns/1ps
module pmc_c2_ctrl
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Requests
    input wire logic c2_request,
    input wire logic break_event,
    input wire logic throttle_active,
    // Clock control outputs
    output logic stop_clock_n,
    output logic c2_active
);
    import pmc_pkg::*;

    pmc_c2_state_type state;
    pmc_c2_state_type next_state;

    // ****************************************
    // State machine
    // ****************************************
    always_comb
    begin
        case (state)
            PMC_C2_RUN:
            begin
                next_state = c2_request ? PMC_C2_SLEEP : PMC_C2_RUN;
            end
            PMC_C2_SLEEP:
            begin
                next_state = break_event ? PMC_C2_RUN : PMC_C2_SLEEP;
            end
            default:
            begin
                next_state = PMC_C2_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= PMC_C2_RUN;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ****************************************
    // Stop clock
    // ****************************************
    // In C2 the pin is held low outright, so the throttle duty has no say.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stop_clock_n <= 1'b1;
        end
        else
        begin
            stop_clock_n <= !((next_state == PMC_C2_SLEEP) || throttle_active);
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            c2_active <= 1'b0;
        end
        else
        begin
            c2_active <= (next_state == PMC_C2_SLEEP);
        end
    end

endmodule

// ===== verilog/pmc_top.sv
// Power-management C2 trigger register and general event status with wake and SCI/SMI routing.
`timescale 1ns/1ps
module pmc_top
(
    // Clock and resets
    input wire logic clk,
    input wire logic resetn,
    input wire logic resume_well_reset_n,
    // I/O register access
    input wire logic [15:0] pm_io_base,
    input wire logic [15:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [3:0] io_byte_en,
    input wire logic [31:0] io_wdata,
    output logic [31:0] io_rdata,
    output logic io_rdata_valid,
    // General purpose inputs
    input wire logic [15:0] gpio_pin,
    input wire logic [15:0] gpio_is_input,
    input wire logic [15:0] gp_input_invert,
    input wire logic [31:0] gp_input_route,
    // Event sources and enables
    input wire logic [pmc_pkg::BUS0_DEVICES-1:0] internal_bus0_power_event,
    input wire logic [31:0] general_event_enable,
    input wire logic sci_select,
    // System sleep state
    input wire pmc_pkg::pmc_sleep_type sleep_state,
    input wire logic s5_power_button_override,
    // Clock control
    input wire logic throttle_enable,
    input wire logic thermal_alarm_n,
    input wire logic throttle_duty_low,
    input wire logic break_event,
    output logic stop_clock_n,
    output logic c2_active,
    // Event outputs
    output logic wake_event,
    output logic sci_active,
    output logic system_mgmt_irq_n
);
    import pmc_pkg::*;

    logic [16:0] pin_s1;
    logic [16:0] pin_s2;
    logic [16:0] pin_s3;
    logic [16:0] pin_stable;
    logic [1:0] sync_count;
    logic sync_filled;
    logic hit_trig;
    logic hit_ges;
    logic c2_request;
    logic throttle_active;
    logic [15:0] gpi_level;
    logic [15:0] gpi_set;
    logic bus0_req;
    logic [31:0] enabled_status;
    logic [31:0] enabled_fresh;
    logic in_s0;
    logic override_s5;
    logic bus0_live;
    logic gpi_sci;
    logic gpi_smi;
    logic gpi_wake;
    logic next_sci;
    logic next_smi;
    logic next_wake;

    pmc_status_if sts ();

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] base, input logic [15:0] off);
        logic [15:0] target;
        target = 16'(base + off);
        return addr == target;
    endfunction

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        logic [31:0] mask;
        mask = 32'h00000000;
        for (int i = 0; i < 4; i++)
        begin
            mask[i*8 +: 8] = {8{be[i]}};
        end
        return mask;
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // A change is taken only once the second and third stages agree.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_s1 <= PIN_IDLE;
            pin_s2 <= PIN_IDLE;
            pin_s3 <= PIN_IDLE;
        end
        else
        begin
            pin_s1 <= {thermal_alarm_n, gpio_pin};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_stable <= PIN_IDLE;
        end
        else
        begin
            pin_stable <= (pin_s2 & ~(pin_s2 ^ pin_s3)) | (pin_stable & (pin_s2 ^ pin_s3));
        end
    end

    // The status bits outlive a core reset, so an inverted input must not see the
    // reset value of the synchroniser as a real level and set a flag by mistake.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync_count <= 2'h0;
        end
        else if (sync_count != SYNC_FILL)
        begin
            sync_count <= 2'(sync_count + 2'h1);
        end
    end

    // The stable stage holds real pin levels only one edge after the count fills,
    // so the gate is registered to keep the reset value of that stage out.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync_filled <= 1'b0;
        end
        else
        begin
            sync_filled <= (sync_count == SYNC_FILL);
        end
    end

    // ****************************************
    // Register decode
    // ****************************************
    assign hit_trig = addr_hit(io_addr, pm_io_base, TRIG_OFFSET);
    assign hit_ges = addr_hit(io_addr, pm_io_base, GES_OFFSET);
    assign c2_request = io_rd && hit_trig;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            io_rdata <= 32'h00000000;
        end
        else if (io_rd && hit_trig)
        begin
            io_rdata <= {24'h000000, TRIG_READ_VALUE};
        end
        else if (io_rd && hit_ges)
        begin
            io_rdata <= sts.status & GES_IMPL_MASK;
        end
        else
        begin
            io_rdata <= 32'h00000000;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            io_rdata_valid <= 1'b0;
        end
        else
        begin
            io_rdata_valid <= io_rd && (hit_trig || hit_ges);
        end
    end

    // A write to the trigger register decodes to nothing here and leaves no trace.
    assign sts.clear_mask = (io_wr && hit_ges) ? (io_wdata & lane_mask(io_byte_en) & GES_IMPL_MASK) : 32'h00000000;

    // ****************************************
    // Event sources
    // ****************************************
    assign gpi_level = pin_stable[15:0] ^ gp_input_invert;
    assign gpi_set = gpi_level & gpio_is_input & {16{sync_filled}};
    assign bus0_req = |internal_bus0_power_event;

    always_comb
    begin
        sts.set_mask = 32'h00000000;
        sts.set_mask[GPI_LSB +: GPI_COUNT] = gpi_set;
        sts.set_mask[BUS0_BIT] = bus0_req;
    end

    pmc_event_status u_status
    (
        .clk(clk),
        .resume_well_reset_n(resume_well_reset_n),
        .sts(sts)
    );

    // ****************************************
    // Event routing
    // ****************************************
    // Only bits with an enable can signal; the thermal override flag has none.
    assign enabled_status = sts.status & general_event_enable & GES_IMPL_MASK;
    assign enabled_fresh = sts.fresh & general_event_enable & GES_IMPL_MASK;
    assign in_s0 = (sleep_state == PMC_S0);
    assign override_s5 = (sleep_state == PMC_S5) && s5_power_button_override;
    assign bus0_live = enabled_status[BUS0_BIT] && !override_s5;

    // SCI and SMI are levels that follow the flags, so an event caught in sleep
    // is reported as soon as the system is back in S0.
    always_comb
    begin
        gpi_sci = 1'b0;
        gpi_smi = 1'b0;
        for (int i = 0; i < GPI_COUNT; i++)
        begin
            if (enabled_status[GPI_LSB + i] && in_s0)
            begin
                if (gp_input_route[2*i +: 2] == ROUTE_SCI)
                begin
                    gpi_sci = 1'b1;
                end
                else if (gp_input_route[2*i +: 2] == ROUTE_SMI)
                begin
                    gpi_smi = 1'b1;
                end
            end
        end
    end

    assign gpi_wake = !in_s0 && (|enabled_fresh[GPI_LSB +: GPI_COUNT]);
    assign next_sci = gpi_sci || (bus0_live && sci_select);
    assign next_smi = gpi_smi || (bus0_live && !sci_select);
    assign next_wake = gpi_wake || (!in_s0 && enabled_fresh[BUS0_BIT] && !override_s5);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sci_active <= 1'b0;
        end
        else
        begin
            sci_active <= next_sci;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            system_mgmt_irq_n <= 1'b1;
        end
        else
        begin
            system_mgmt_irq_n <= !next_smi;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wake_event <= 1'b0;
        end
        else
        begin
            wake_event <= next_wake;
        end
    end

    // ****************************************
    // Clock control
    // ****************************************
    // Software or thermal throttling only shapes the pin outside C2.
    assign throttle_active = throttle_duty_low && (throttle_enable || !pin_stable[16]);

    pmc_c2_ctrl u_c2
    (
        .clk(clk),
        .resetn(resetn),
        .c2_request(c2_request),
        .break_event(break_event),
        .throttle_active(throttle_active),
        .stop_clock_n(stop_clock_n),
        .c2_active(c2_active)
    );

endmodule

// ===== testbench/pmc_checker.sv
// Port-level checks on the power-management block.
`timescale 1ns/1ps
module pmc_checker
(
    // Clock and resets
    input wire logic clk,
    input wire logic resetn,
    input wire logic resume_well_reset_n,
    // Register access
    input wire logic [15:0] pm_io_base,
    input wire logic [15:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [31:0] io_rdata,
    input wire logic io_rdata_valid,
    // Events and state
    input wire logic [pmc_pkg::BUS0_DEVICES-1:0] internal_bus0_power_event,
    input wire logic [31:0] general_event_enable,
    input wire logic sci_select,
    input wire pmc_pkg::pmc_sleep_type sleep_state,
    input wire logic s5_power_button_override,
    input wire logic break_event,
    // Outputs
    input wire logic stop_clock_n,
    input wire logic c2_active,
    input wire logic wake_event,
    input wire logic sci_active
);
    import pmc_pkg::*;
    // ****
    // Checks
    // ****
    logic trig, s0sci, pbo;
    assign trig = io_addr == pm_io_base + TRIG_OFFSET;
    assign s0sci = general_event_enable[BUS0_BIT] && sleep_state == PMC_S0 && sci_select;
    assign pbo = sleep_state == PMC_S5 && s5_power_button_override && general_event_enable[31:16] == 16'h0000;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn || !resume_well_reset_n);
    chk_trig_reads_zero: assert property (io_rd && trig |=> io_rdata_valid && io_rdata == 32'h00000000)
        else $error("level-2 read not zero");
    chk_trig_write_void: assert property (io_wr && trig && !c2_active |=> !c2_active && !io_rdata_valid)
        else $error("level-2 write had an effect");
    chk_c2_read_entry: assert property (io_rd && trig |=> !stop_clock_n && c2_active)
        else $error("no C2 entry after trigger read");
    chk_c2_holds_low: assert property (c2_active && !break_event |=> c2_active && !stop_clock_n)
        else $error("stop clock released inside C2");
    chk_bus0_sci_raise: assert property (s0sci && |internal_bus0_power_event ##1 s0sci |=> sci_active)
        else $error("bus-0 event raised no SCI");
    chk_s0_no_wake: assert property ((sleep_state == PMC_S0) [*3] |-> !wake_event)
        else $error("wake pulse in working state");
    chk_override_quiet: assert property (pbo [*3] |-> !wake_event)
        else $error("wake after override S5");
    chk_resume_clears: assert property (disable iff (!resetn) !resume_well_reset_n [*2] |-> !sci_active)
        else $error("SCI held through resume reset");
    cover property (c2_active && break_event);
    cover property (wake_event);
    cover property (sci_active);
endmodule
bind pmc_top pmc_checker chk (.*);

// ===== testbench/pmc_host_model.sv
// Host model issuing I/O reads and writes to the power-management block.
`timescale 1ns/1ps
module pmc_host_model
(
    // Clock and base
    input wire logic clk,
    input wire logic [15:0] pm_io_base,
    // I/O cycle
    output logic [15:0] io_addr,
    output logic io_rd,
    output logic io_wr,
    output logic [3:0] io_byte_en,
    output logic [31:0] io_wdata
);
    // ****
    // I/O cycles
    // ****
    initial
    begin
        io_addr = 16'h0000;
        io_rd = 1'b0;
        io_wr = 1'b0;
        io_byte_en = 4'h0;
        io_wdata = 32'h00000000;
    end
    // Idle address and data lines carry the inverse of the last value, so a stale match cannot pass.
    task automatic cycle(input logic rd, input logic [15:0] off, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        io_addr <= pm_io_base + off;
        io_rd <= rd;
        io_wr <= !rd;
        io_wdata <= d;
        io_byte_en <= be;
        @(posedge clk);
        io_rd <= 1'b0;
        io_wr <= 1'b0;
        io_addr <= ~(pm_io_base + off);
        io_wdata <= ~d;
        #1;
    endtask
endmodule

// ===== testbench/pmc_top_test.sv
// Self-checking bench for the power-management C2 and event status block.
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        checks++; \
        if ((g) !== (e)) \
        begin \
            num_errors++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
        end \
    end
module pmc_top_test;
    import pmc_pkg::*;
    logic clk, resetn, resume_well_reset_n, io_rd, io_wr, io_rdata_valid, sci_select, s5_power_button_override;
    logic throttle_enable, thermal_alarm_n, throttle_duty_low, break_event, stop_clock_n, c2_active;
    logic wake_event, sci_active, system_mgmt_irq_n;
    logic [15:0] pm_io_base, io_addr, gpio_pin, gpio_is_input, gp_input_invert;
    logic [3:0] io_byte_en;
    logic [31:0] io_wdata, io_rdata, gp_input_route, general_event_enable, seed;
    logic [BUS0_DEVICES-1:0] internal_bus0_power_event;
    pmc_sleep_type sleep_state;
    int num_errors, checks, i;
    pmc_top dut (.*);
    pmc_host_model host (.*);
    always #4 clk = ~clk;
    // ****
    // Helpers
    // ****
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] gpi_exp(input logic [15:0] p, input logic [15:0] v, input logic [15:0] e);
        return {(p ^ v) & e, 16'h0000};
    endfunction
    task automatic rdc(input logic [15:0] off, input logic [31:0] e);
        host.cycle(1'b1, off, seed, 4'h0);
        `CHK({io_rdata_valid, io_rdata}, {1'b1, e})
    endtask
    task automatic bus0_pulse;
        @(posedge clk);
        internal_bus0_power_event <= BUS0_DEVICES'(1) << seed[2:0];
        @(posedge clk);
        internal_bus0_power_event <= '0;
    endtask
    // Wake is a one-cycle pulse, so every cycle of the window is looked at.
    task automatic wake_chk(input logic e);
        logic seen;
        seen = 1'b0;
        repeat (8)
        begin
            @(posedge clk);
            #1;
            seen = seen | wake_event;
        end
        `CHK(seen, e)
    endtask
    task automatic final_report;
        $display("checks=%0d errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    initial
    begin
        clk = 1'b0;
        resetn = 1'b0;
        resume_well_reset_n = 1'b0;
        num_errors = 0;
        checks = 0;
        seed = 32'h988683B1;
        pm_io_base = seed[15:0] & 16'hFFC0;
        gp_input_invert = seed[31:16];
        gpio_pin = seed[31:16];
        gpio_is_input = 16'hFFFF;
        gp_input_route = 32'h00000000;
        internal_bus0_power_event = '0;
        general_event_enable = 32'h00000000;
        sci_select = 1'b0;
        sleep_state = PMC_S0;
        s5_power_button_override = 1'b0;
        throttle_enable = 1'b0;
        thermal_alarm_n = 1'b1;
        throttle_duty_low = 1'b0;
        break_event = 1'b0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        resume_well_reset_n <= 1'b1;
        rdc(GES_OFFSET, GES_RESET);
        rdc(TRIG_OFFSET, 32'h00000000);
        `CHK({stop_clock_n, c2_active}, 2'b01)
        @(posedge clk);
        throttle_enable <= 1'b1;
        thermal_alarm_n <= 1'b0;
        throttle_duty_low <= 1'b1;
        repeat (20) @(posedge clk);
        break_event <= 1'b1;
        #1;
        `CHK({stop_clock_n, c2_active}, 2'b01)
        @(posedge clk);
        break_event <= 1'b0;
        throttle_enable <= 1'b0;
        thermal_alarm_n <= 1'b1;
        throttle_duty_low <= 1'b0;
        #1;
        `CHK({stop_clock_n, c2_active}, 2'b00)
        host.cycle(1'b0, TRIG_OFFSET, seed, 4'hF);
        `CHK({stop_clock_n, c2_active}, 2'b10)
        $display("test c2 done");
        for (i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            @(posedge clk);
            sci_select <= i[0];
            general_event_enable <= {seed[31:16], 16'h2000};
            bus0_pulse();
            @(posedge clk);
            #1;
            `CHK({sci_active, system_mgmt_irq_n}, {i[0], i[0]})
            rdc(GES_OFFSET, 32'h00002000);
            host.cycle(1'b0, GES_OFFSET, 32'hFFFFDFFF, 4'hF);
            rdc(GES_OFFSET, 32'h00002000);
            host.cycle(1'b0, GES_OFFSET, 32'h00002000, 4'h2);
            rdc(GES_OFFSET, 32'h00000000);
        end
        $display("test bus0 done");
        for (i = 0; i < 6; i++)
        begin
            seed = lfsr(seed);
            @(posedge clk);
            gpio_is_input <= seed[31:16];
            general_event_enable <= 32'h00010000 << seed[3:0];
            gp_input_route <= {30'h0, ROUTE_SCI} << (2 * seed[3:0]);
            sleep_state <= i[0] ? PMC_S2 : PMC_S0;
            @(posedge clk);
            gpio_pin[seed[3:0]] <= ~gpio_pin[seed[3:0]];
            wake_chk(i[0] & seed[16 + seed[3:0]]);
            `CHK(sci_active, !i[0] & seed[16 + seed[3:0]])
            rdc(GES_OFFSET, gpi_exp(gpio_pin, gp_input_invert, gpio_is_input));
            @(posedge clk);
            gpio_pin[seed[3:0]] <= ~gpio_pin[seed[3:0]];
            repeat (5) @(posedge clk);
            host.cycle(1'b0, GES_OFFSET, 32'hFFFF0000, 4'hC);
            rdc(GES_OFFSET, 32'h00000000);
        end
        $display("test gpi done");
        @(posedge clk);
        general_event_enable <= 32'h00002000;
        sleep_state <= PMC_S3;
        bus0_pulse();
        wake_chk(1'b1);
        `CHK(sci_active, 1'b1)
        host.cycle(1'b0, GES_OFFSET, 32'h00002000, 4'h2);
        @(posedge clk);
        sleep_state <= PMC_S5;
        s5_power_button_override <= 1'b1;
        bus0_pulse();
        wake_chk(1'b0);
        `CHK(sci_active, 1'b0)
        @(posedge clk);
        resetn <= 1'b0;
        sleep_state <= PMC_S0;
        s5_power_button_override <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rdc(GES_OFFSET, 32'h00002000);
        @(posedge clk);
        resume_well_reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        resume_well_reset_n <= 1'b1;
        rdc(GES_OFFSET, 32'h00000000);
        $display("test sleep and resets done");
        final_report();
    end
endmodule
